//--- common/ira_pkg.sv
// constants, field layouts and carrier types for the interrupt routing
// and auto-sleep block; shared by the top module and its two helpers.
// How it works
// - routing bit 0 sends a source to pin b, bit 1 to pin a.
// - each pin is the OR of every enabled source routed to it.
// - eight-bit inactivity count sets quiet time; sleep only when sleep enable is 1.
// - one count unit is 320 ms, or 640 ms at the slowest active rate.
// - hybrid mode halves the effective rate, doubling each count unit.
// - enabled restart source before expiry cancels sleep and clears the counter.
// - quiet for the programmed time enters sleep at the sleep rate.
// - asleep, an enabled wake source with its wake bit set restores active rate.
// - sources not enabled are ignored by restart and wake logic.
// - functions without wake bit are suspended asleep, restored on wake except data-ready.
// - every sleep/active transition with the sleep-change enable bit set raises sleep-change flag, held until system state read.
// - with fifo gating, sleep entry keeps fifo, sets gate error, blocks intake.
// - after a gated transition no intake until host empties the fifo.
// - with fifo gating, the sleep-change flag never blocks transitions.
// - a source's enable bit gates it before routing; disabled never drives a pin.
// - polarity bit 0 makes both pins active low, 1 active high.
// - fifo is flushed on every sample rate change unless a gated transition holds it, automatic ones included.
package ira_pkg;

  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_SYS_STATE = 8'h0b;
  localparam logic [7:0] IDX_INACT = 8'h29;
  localparam logic [7:0] IDX_ROUTING = 8'h2e;
  localparam logic [7:0] IDX_IRQ_EN = 8'h30;
  localparam logic [7:0] IDX_WAKE = 8'h31;
  localparam logic [7:0] IDX_RATE = 8'h32;
  localparam logic [7:0] IDX_MAG = 8'h33;
  localparam logic [7:0] IDX_SOURCE = 8'h34;

  // reset values
  localparam logic [7:0] RST_INACT = 8'h00;
  localparam logic [7:0] RST_ROUTING = 8'h00;
  localparam logic [7:0] RST_ZERO = 8'h00;

  // source bit positions within the eight-bit source vector, and the slowest rate code
  localparam int SRC_SLEEP_CHG = 7;
  localparam int SRC_QUEUE = 6;
  localparam int SAMPLE_READY_EVENT = 0;
  localparam logic [2:0] RATE_SLOWEST = 3'h7;

  // timing: one inactivity unit
  localparam int UNIT_MS = 320;
  localparam int CLK_HZ = 20_000_000;
  localparam int UNIT_CYCLES = UNIT_MS * (CLK_HZ / 1000);

  // axi response codes
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [7:0] irq_en;      // 7 sleep change .. 0 data ready
    logic [7:0] routing;     // irq_pin_routing
    logic [7:0] inact;       // inactivity_count
    logic fifo_gate;
    logic [4:0] wake;        // trans, orient, pulse, ffmt, vecm
    logic ipol;
    logic [2:0] active_rate_sel;
    logic [1:0] sleep_rate;
    logic sleep_en;
    logic hybrid;
    logic [1:0] mag_en;      // 1 threshold, 0 vector magnitude
    logic [1:0] mag_wake;
    logic [1:0] mag_route;
  } ira_cfg_t;

  typedef struct packed {
    logic en;
    logic [7:0] idx;
    logic [7:0] data;
  } ira_wr_t;

  typedef struct packed {
    logic en;
    logic [7:0] idx;
  } ira_rd_t;

  typedef enum logic {ST_ACTIVE, ST_SLEEP} ira_state_t;

endpackage

//--- src/ira_axil_slave.sv
// axi4-lite slave front end for the routing/auto-sleep registers.
// assumes the owner decodes indices and returns read data combinationally.
`timescale 1ns/1ps
module ira_axil_slave
  import ira_pkg::*;
#(
  parameter int ADDR_W = 10
) (
  input wire logic sys_clk,               // system clock
  input wire logic rst_n,                 // synchronised reset
  input wire logic [ADDR_W-1:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid,         // write address valid
  output logic s_axi_awready,             // write address ready
  input wire logic [31:0] s_axi_wdata,    // write data
  input wire logic [3:0] s_axi_wstrb,     // byte enables
  input wire logic s_axi_wvalid,          // write data valid
  output logic s_axi_wready,              // write data ready
  output logic [1:0] s_axi_bresp,         // write response
  output logic s_axi_bvalid,              // write response valid
  input wire logic s_axi_bready,          // write response ready
  input wire logic [ADDR_W-1:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid,         // read address valid
  output logic s_axi_arready,             // read address ready
  output logic [31:0] s_axi_rdata,        // read data
  output logic [1:0] s_axi_rresp,         // read response
  output logic s_axi_rvalid,              // read data valid
  input wire logic s_axi_rready,          // read data ready
  output ira_wr_t wr,                     // register write strobe
  output ira_rd_t rd,                     // register read strobe
  input wire logic wr_hit,                // write index is mapped
  input wire logic rd_hit,                // read index is mapped
  input wire logic [7:0] rd_data          // read value for rd.idx
);

  logic aw_hold_reg, w_hold_reg, bvalid_reg, rvalid_reg;
  logic [ADDR_W-1:0] aw_addr_reg;
  logic [7:0] w_data_reg;
  logic w_lane_reg;
  logic [1:0] bresp_reg, rresp_reg;
  logic [31:0] rdata_reg;

  // handshakes and strobes
  wire do_write = aw_hold_reg && w_hold_reg && !bvalid_reg;
  wire aw_take = s_axi_awvalid && s_axi_awready;
  wire w_take = s_axi_wvalid && s_axi_wready;
  wire ar_take = s_axi_arvalid && s_axi_arready;
  assign s_axi_awready = !aw_hold_reg && !bvalid_reg;
  assign s_axi_wready = !w_hold_reg && !bvalid_reg;
  assign s_axi_arready = !rvalid_reg;
  assign wr = '{en: do_write && w_lane_reg, idx: 8'(aw_addr_reg >> 2), data: w_data_reg};
  assign rd = '{en: ar_take, idx: 8'(s_axi_araddr >> 2)};
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rresp = rresp_reg;
  assign s_axi_rdata = rdata_reg;

  // write address and data captured in either order
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_hold_reg <= 1'b0;
      w_hold_reg <= 1'b0;
      aw_addr_reg <= '0;
      w_data_reg <= 8'h00;
      w_lane_reg <= 1'b0;
    end else begin
      if (aw_take) begin
        aw_hold_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end else if (do_write) aw_hold_reg <= 1'b0;
      if (w_take) begin
        w_hold_reg <= 1'b1;
        w_data_reg <= s_axi_wdata[7:0];
        w_lane_reg <= s_axi_wstrb[0];
      end else if (do_write) w_hold_reg <= 1'b0;
    end
  end

  // responses
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
      rvalid_reg <= 1'b0;
      rresp_reg <= RESP_OKAY;
      rdata_reg <= 32'h0000_0000;
    end else begin
      if (do_write) begin
        bvalid_reg <= 1'b1;
        bresp_reg <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) bvalid_reg <= 1'b0;
      if (ar_take) begin
        rvalid_reg <= 1'b1;
        rresp_reg <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        rdata_reg <= {24'h00_0000, rd_hit ? rd_data : 8'h00};
      end else if (s_axi_rready) rvalid_reg <= 1'b0;
    end
  end

  // a taken write gets its response on the following cycle
  bresp_after_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    do_write |=> s_axi_bvalid)
    else $error("write response missing");

endmodule

//--- src/ira_inact_timer.sv
// inactivity timer: counts quiet units and reports when the limit is met.
// assumes run and restart come from logic on the same clock.
`timescale 1ns/1ps
module ira_inact_timer
  import ira_pkg::*;
#(
  parameter int STEP_CYCLES = UNIT_CYCLES
) (
  input wire logic sys_clk,        // system clock
  input wire logic rst_n,          // synchronised reset
  input wire logic run,            // active with sleep enabled
  input wire logic restart,        // clear the count
  input wire logic [1:0] unit_mult, // unit length is 2^mult steps
  input wire logic [7:0] limit,    // programmed unit count
  output logic expire              // quiet time reached
);

  localparam int PW = $clog2(STEP_CYCLES + 1);
  logic [PW-1:0] presc_reg;
  logic [1:0] sub_reg;
  logic [8:0] units_reg;

  // step and unit enables
  wire step_tick = presc_reg == PW'(STEP_CYCLES - 1);
  wire [1:0] sub_last = (2'h1 << unit_mult) - 2'h1;
  wire unit_done = step_tick && (sub_reg == sub_last);
  wire clear = !run || restart;
  assign expire = run && !restart && (units_reg >= {1'b0, limit});

  // prescaler, sub-unit and unit counters
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      presc_reg <= '0;
      sub_reg <= 2'h0;
      units_reg <= 9'h000;
    end else if (clear) begin
      presc_reg <= '0;
      sub_reg <= 2'h0;
      units_reg <= 9'h000;
    end else begin
      presc_reg <= step_tick ? '0 : presc_reg + PW'(1);
      if (step_tick) sub_reg <= unit_done ? 2'h0 : sub_reg + 2'h1;
      if (unit_done && !units_reg[8]) units_reg <= units_reg + 9'h001;
    end
  end

  // with a nonzero limit, a restart never lets the timer report expiry in the next cycle
  restart_clear_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (restart && run && limit != 8'h00) |=> !expire)
    else $error("timer expired right after restart");

endmodule

//--- src/ira_irq_sleep.sv
// interrupt routing and auto-sleep controller, top module.
// assumes event sources, fifo status and fifo control run on sys_clk.
//
// Local design decision: the AXI4-Lite register port.
`timescale 1ns/1ps
module ira_irq_sleep
  import ira_pkg::*;
#(
  parameter int STEP_CYCLES = UNIT_CYCLES,
  parameter int ADDR_W = 10
) (
  input wire logic sys_clk,               // 20 MHz system clock
  input wire logic rstn,                  // async reset, active low
  input wire logic [ADDR_W-1:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid,         // write address valid
  output logic s_axi_awready,             // write address ready
  input wire logic [31:0] s_axi_wdata,    // write data
  input wire logic [3:0] s_axi_wstrb,     // byte enables
  input wire logic s_axi_wvalid,          // write data valid
  output logic s_axi_wready,              // write data ready
  output logic [1:0] s_axi_bresp,         // write response
  output logic s_axi_bvalid,              // write response valid
  input wire logic s_axi_bready,          // write response ready
  input wire logic [ADDR_W-1:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid,         // read address valid
  output logic s_axi_arready,             // read address ready
  output logic [31:0] s_axi_rdata,        // read data
  output logic [1:0] s_axi_rresp,         // read response
  output logic s_axi_rvalid,              // read data valid
  input wire logic s_axi_rready,          // read data ready
  input wire logic [6:0] acc_events,      // queue,trans,orient,pulse,ffmt,vecm,ready
  input wire logic [1:0] mag_events,      // mag threshold, mag vector magnitude
  input wire logic fifo_empty,            // fifo holds no samples
  output logic irq_pin_a,                 // interrupt pin a
  output logic irq_pin_b,                 // interrupt pin b
  output logic [2:0] sample_rate,         // current system rate code
  output logic sleep_active,              // in auto-sleep
  output logic fifo_flush,                // one-cycle fifo flush
  output logic fifo_intake_en,            // fifo may take samples
  output logic [6:0] func_run,            // trans..vecm, mag thr, mag vecm enabled
  output logic drdy_run                   // data-ready function enabled
);

  logic rst_s1_reg, rst_n;
  ira_cfg_t cfg_reg, cfg_next;
  ira_state_t state_reg;
  ira_wr_t wr;
  ira_rd_t rd;
  logic sleep_chg_reg, gate_hold_reg, fgerr_reg, flush_reg, drdy_run_reg;
  logic pin_a_reg, pin_b_reg;
  logic [2:0] rate_prev_reg;
  logic [6:0] func_run_reg;
  logic expire;
  logic [7:0] rd_data;
  logic rd_hit, wr_hit;

  // reset release through two flops
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rst_s1_reg <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_n <= rst_s1_reg;
    end
  end

  ira_axil_slave #(.ADDR_W(ADDR_W)) u_bus (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .wr(wr),
    .rd(rd),
    .wr_hit(wr_hit),
    .rd_hit(rd_hit),
    .rd_data(rd_data)
  );

  // index decode for the two bus directions
  assign wr_hit = wr.idx inside {IDX_SYS_STATE, IDX_INACT, IDX_ROUTING, IDX_IRQ_EN, IDX_WAKE, IDX_RATE,
                               IDX_MAG, IDX_SOURCE};
  wire rd_sys = rd.en && (rd.idx == IDX_SYS_STATE);
  wire wr_irq_en = wr.en && (wr.idx == IDX_IRQ_EN);
  wire asleep = state_reg == ST_SLEEP;

  // configuration write decode
  always_comb begin
    cfg_next = cfg_reg;
    if (wr.en) begin
      unique case (wr.idx)
        IDX_INACT: cfg_next.inact = wr.data;
        IDX_ROUTING: cfg_next.routing = wr.data;
        IDX_IRQ_EN: cfg_next.irq_en = wr.data;
        IDX_WAKE: begin
          cfg_next.fifo_gate = wr.data[7];
          cfg_next.wake = wr.data[6:2];
          cfg_next.ipol = wr.data[1];
        end
        IDX_RATE: begin
          cfg_next.active_rate_sel = wr.data[2:0];
          cfg_next.sleep_rate = wr.data[4:3];
          cfg_next.sleep_en = wr.data[5];
          cfg_next.hybrid = wr.data[6];
        end
        IDX_MAG: begin
          cfg_next.mag_en = wr.data[1:0];
          cfg_next.mag_wake = wr.data[3:2];
          cfg_next.mag_route = wr.data[5:4];
        end
        default: cfg_next = cfg_reg;
      endcase
    end
  end

  // configuration storage, all fields zero after reset
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_reg <= '{irq_en: RST_ZERO, routing: RST_ROUTING, inact: RST_INACT, default: '0};
    end else begin
      cfg_reg <= cfg_next;
    end
  end

  // enable gating ahead of routing; sleep-change flag is source 7
  wire [7:0] src_all = {sleep_chg_reg, acc_events};
  wire [7:0] src_en = src_all & cfg_reg.irq_en;
  wire [1:0] mag_en_ev = mag_events & cfg_reg.mag_en;

  // per-pin OR of routed sources
  wire pin_a_lvl = |(src_en & cfg_reg.routing) | |(mag_en_ev & cfg_reg.mag_route);
  wire pin_b_lvl = |(src_en & ~cfg_reg.routing) | |(mag_en_ev & ~cfg_reg.mag_route);

  // restart excludes data ready and sleep change; wake also excludes the queue
  wire restart_ev = |src_en[SRC_QUEUE:1] | |mag_en_ev;
  wire wake_ev = |(src_en[5:1] & cfg_reg.wake) | |(mag_en_ev & cfg_reg.mag_wake);

  // transitions; the sleep-change flag has no say in them
  wire go_sleep = !asleep && cfg_reg.sleep_en && expire && !restart_ev;
  wire go_wake = asleep && (wake_ev || !cfg_reg.sleep_en);
  wire transition = go_sleep || go_wake;

  // rate selection and change detection
  wire [2:0] rate_now = asleep ? {1'b1, cfg_reg.sleep_rate} : cfg_reg.active_rate_sel;
  wire rate_changed = rate_now != rate_prev_reg;
  wire [1:0] unit_mult = {1'b0, cfg_reg.active_rate_sel == RATE_SLOWEST} + {1'b0, cfg_reg.hybrid};

  ira_inact_timer #(.STEP_CYCLES(STEP_CYCLES)) u_timer (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .run(!asleep && cfg_reg.sleep_en),
    .restart(restart_ev || rate_changed),
    .unit_mult(unit_mult),
    .limit(cfg_reg.inact),
    .expire(expire)
  );

  // active/sleep state
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_ACTIVE;
    end else if (go_sleep) begin
      state_reg <= ST_SLEEP;
    end else if (go_wake) begin
      state_reg <= ST_ACTIVE;
    end
  end

  // sleep-change flag: a new transition wins over the clearing read
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sleep_chg_reg <= 1'b0;
    end else if (transition && cfg_reg.irq_en[SRC_SLEEP_CHG]) begin
      sleep_chg_reg <= 1'b1;
    end else if (rd_sys) begin
      sleep_chg_reg <= 1'b0;
    end
  end

  // fifo gating and gate error; a gated transition wins over emptiness
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      gate_hold_reg <= 1'b0;
      fgerr_reg <= 1'b0;
    end else begin
      if (transition && cfg_reg.fifo_gate) gate_hold_reg <= 1'b1;
      else if (fifo_empty) gate_hold_reg <= 1'b0;
      if (go_sleep && cfg_reg.fifo_gate) fgerr_reg <= 1'b1;
      else if (fifo_empty) fgerr_reg <= 1'b0;
    end
  end

  // flush on rate change unless the fifo is being preserved
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rate_prev_reg <= 3'h0;
      flush_reg <= 1'b0;
    end else begin
      rate_prev_reg <= rate_now;
      flush_reg <= rate_changed && !gate_hold_reg;
    end
  end

  // function suspension while asleep; data ready stays off after waking
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      func_run_reg <= 7'h7f;
      drdy_run_reg <= 1'b1;
    end else begin
      func_run_reg <= asleep ? {cfg_reg.wake, cfg_reg.mag_wake} : 7'h7f;
      if (go_sleep) drdy_run_reg <= 1'b0;
      else if (wr_irq_en && wr.data[SAMPLE_READY_EVENT]) drdy_run_reg <= 1'b1;
    end
  end

  // pins with polarity applied; idle high after reset since polarity resets low
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_a_reg <= 1'b1;
      pin_b_reg <= 1'b1;
    end else begin
      pin_a_reg <= cfg_reg.ipol ? pin_a_lvl : !pin_a_lvl;
      pin_b_reg <= cfg_reg.ipol ? pin_b_lvl : !pin_b_lvl;
    end
  end

  // read mux; source register lets the host tell sources apart
  always_comb begin
    rd_hit = 1'b1;
    unique case (rd.idx)
      IDX_SYS_STATE: rd_data = {fgerr_reg, 5'h00, sleep_chg_reg, asleep};
      IDX_INACT: rd_data = cfg_reg.inact;
      IDX_ROUTING: rd_data = cfg_reg.routing;
      IDX_IRQ_EN: rd_data = cfg_reg.irq_en;
      IDX_WAKE: rd_data = {cfg_reg.fifo_gate, cfg_reg.wake, cfg_reg.ipol, 1'b0};
      IDX_RATE: rd_data = {1'b0, cfg_reg.hybrid, cfg_reg.sleep_en, cfg_reg.sleep_rate, cfg_reg.active_rate_sel};
      IDX_MAG: rd_data = {2'h0, cfg_reg.mag_route, cfg_reg.mag_wake, cfg_reg.mag_en};
      IDX_SOURCE: rd_data = src_en;
      default: begin
        rd_data = 8'h00;
        rd_hit = 1'b0;
      end
    endcase
  end

  // outputs
  assign irq_pin_a = pin_a_reg;
  assign irq_pin_b = pin_b_reg;
  assign sample_rate = rate_prev_reg;
  assign sleep_active = asleep;
  assign fifo_flush = flush_reg;
  assign fifo_intake_en = !gate_hold_reg;
  assign func_run = func_run_reg;
  assign drdy_run = drdy_run_reg;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  pin_a_follow_a: assert property (##1 irq_pin_a == ($past(pin_a_lvl) ^ !$past(cfg_reg.ipol)))
    else $error("pin a level or polarity wrong");
  disabled_quiet_a: assert property ((cfg_reg.irq_en == 8'h00 && cfg_reg.mag_en == 2'h0)
    |-> !pin_a_lvl && !pin_b_lvl)
    else $error("disabled source reached a pin");
  no_sleep_off_a: assert property ((!asleep && !cfg_reg.sleep_en) |=> !asleep)
    else $error("slept with sleep disabled");
  wake_up_a: assert property ((asleep && wake_ev) |=> !asleep ##1 sample_rate == $past(cfg_reg.active_rate_sel, 2))
    else $error("wake source did not restore active rate");
  stay_asleep_a: assert property ((asleep && cfg_reg.sleep_en && !wake_ev) |=> asleep)
    else $error("woke without enabled wake source");
  change_flag_a: assert property ((transition && cfg_reg.irq_en[SRC_SLEEP_CHG]) |=> sleep_chg_reg [*1] ##0
    (sleep_chg_reg || $past(rd_sys)))
    else $error("sleep change flag not raised");
  gate_error_a: assert property ((go_sleep && cfg_reg.fifo_gate) |=> fgerr_reg && !fifo_intake_en ##1 !fifo_flush)
    else $error("gated sleep entry did not hold fifo");
  flush_rate_a: assert property ((rate_changed && !gate_hold_reg) |=> fifo_flush)
    else $error("rate change without flush");
  sleep_entry_a: assert property (go_sleep |=> asleep ##1 (sample_rate[2] || !asleep))
    else $error("sleep entry or sleep rate missing");

endmodule

//--- test/ira_host_model.sv
// host-side fifo model: fills while intake is open, drained by the host.
// assumes flush and intake enable come from the block under test.
`timescale 1ns/1ps
module ira_host_model (
  input wire logic sys_clk,        // system clock
  input wire logic fifo_flush,     // flush pulse
  input wire logic fifo_intake_en, // intake open
  output logic fifo_empty          // no samples held
);
  logic [7:0] tick_reg = 8'h00;
  logic [3:0] level_reg = 4'h0;
  assign fifo_empty = (level_reg == 4'h0);
  // a sample every 16 cycles, host drains every 256, flush empties at once
  always_ff @(posedge sys_clk) begin
    tick_reg <= tick_reg + 8'h01;
    if (fifo_flush || tick_reg == 8'hff) level_reg <= 4'h0;
    else if (fifo_intake_en && tick_reg[3:0] == 4'hf && level_reg != 4'hf) level_reg <= level_reg + 4'h1;
  end
endmodule

//--- test/testbench.sv
// self-checking bench: axi4-lite host, event stimulus, pin and state checks.
// assumes the top module runs with a short inactivity step.
`timescale 1ns/1ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin bad_count++; $display("BAD %0t got %h exp %h", $time, g, e); end end
module testbench;
  import ira_pkg::*;
  logic sys_clk = 0, rstn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, fifo_empty;
  logic irq_pin_a, irq_pin_b, sleep_active, fifo_flush, fifo_intake_en, drdy_run;
  logic [9:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp, mag_events = '0;
  logic [6:0] acc_events = '0, func_run;
  logic [2:0] sample_rate;
  logic [16:0] rnd = 17'd96319;
  logic [33:0] expq[$];
  logic [33:0] exp_rd;
  int bad_count = 0, samples_checked = 0, cyc = 0, t0, f0, flush_cnt = 0;
  ira_irq_sleep #(.STEP_CYCLES(4)) u_dut (.sys_clk, .rstn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .acc_events, .mag_events, .fifo_empty, .irq_pin_a, .irq_pin_b, .sample_rate, .sleep_active, .fifo_flush,
    .fifo_intake_en, .func_run, .drdy_run);
  ira_host_model u_host (.sys_clk, .fifo_flush, .fifo_intake_en, .fifo_empty);
  initial forever #25 sys_clk = ~sys_clk;
  // cycle count and hang limit
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      final_report();
    end
  end
  // read responses against the oldest note
  always @(posedge sys_clk) if (s_axi_rvalid && s_axi_rready) begin
    exp_rd = expq.pop_front();
    `CHK({s_axi_rresp, s_axi_rdata}, exp_rd)
  end
  // flush pulses seen, for the rate change checks
  always @(posedge sys_clk) if (fifo_flush) flush_cnt++;
  function automatic logic [16:0] lfsr(input logic [16:0] v);
    return {v[15:0], v[16] ^ v[13]};
  endfunction
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [2:0] p, h;
    p = 3'b111;
    @(posedge sys_clk);
    s_axi_awaddr <= {idx, 2'b00};
    s_axi_wdata <= {24'h0, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
    while (p != 3'b000) begin
      @(negedge sys_clk);
      h = p & {s_axi_awready, s_axi_wready, s_axi_bvalid};
      if (h[0]) `CHK(s_axi_bresp, RESP_OKAY)
      @(posedge sys_clk);
      p = p & ~h;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= p;
    end
  endtask
  task automatic rd(input logic [7:0] idx, input logic [33:0] e);
    logic [1:0] p, h;
    p = 2'b11;
    expq.push_back(e);
    @(posedge sys_clk);
    s_axi_araddr <= {idx, 2'b00};
    {s_axi_arvalid, s_axi_rready} <= 2'b11;
    while (p != 2'b00) begin
      @(negedge sys_clk);
      h = p & {s_axi_arready, s_axi_rvalid};
      @(posedge sys_clk);
      p = p & ~h;
      {s_axi_arvalid, s_axi_rready} <= p;
    end
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask
  task automatic final_report;
    $display("checked %0d bad %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (2) @(posedge sys_clk);
    rstn <= 1'b1;
    repeat (4) @(posedge sys_clk);
    rd(IDX_INACT, {RESP_OKAY, 32'h0});
    rd(IDX_ROUTING, {RESP_OKAY, 32'h0});
    rd(8'hfc, {RESP_SLVERR, 32'h0});
    `CHK({irq_pin_a, irq_pin_b}, 2'b11)
    wr(IDX_IRQ_EN, 8'hff);
    wr(IDX_WAKE, 8'h42);
    for (int i = 0; i < 7; i++) begin
      rnd = lfsr(rnd);
      wr(IDX_ROUTING, rnd[7:0]);
      acc_events <= 7'h01 << i;
      settle(3);
      `CHK({irq_pin_a, irq_pin_b}, {rnd[i], ~rnd[i]})
    end
    wr(IDX_ROUTING, rnd[7:0]);
    acc_events <= 7'h7f;
    settle(3);
    `CHK({irq_pin_a, irq_pin_b}, {|rnd[6:0], ~&rnd[6:0]})
    wr(IDX_IRQ_EN, 8'h00);
    settle(3);
    `CHK({irq_pin_a, irq_pin_b}, 2'b00)
    wr(IDX_MAG, 8'h13);
    mag_events <= 2'b01;
    settle(3);
    `CHK({irq_pin_a, irq_pin_b}, 2'b10)
    @(posedge sys_clk) mag_events <= 2'b10;
    settle(3);
    `CHK({irq_pin_a, irq_pin_b}, 2'b01)
    @(posedge sys_clk) mag_events <= 2'b00;
    wr(IDX_IRQ_EN, 8'hff);
    acc_events <= 7'h20;
    wr(IDX_INACT, 8'h02);
    wr(IDX_RATE, 8'h33);
    settle(40);
    `CHK(sleep_active, 1'b0)
    @(posedge sys_clk);
    acc_events <= 7'h00;
    t0 = cyc;
    f0 = flush_cnt;
    for (int k = 0; k < 100 && sleep_active !== 1'b1; k++) @(negedge sys_clk);
    `CHK(sleep_active, 1'b1)
    `CHK((cyc - t0) inside {[9:10]}, 1'b1)
    settle(3);
    `CHK(sample_rate, 3'b110)
    `CHK(flush_cnt - f0, 1)
    `CHK({func_run, drdy_run}, 8'h80)
    rd(IDX_SYS_STATE, {RESP_OKAY, 32'h3});
    rd(IDX_SYS_STATE, {RESP_OKAY, 32'h1});
    acc_events <= 7'h20;
    settle(3);
    `CHK(sleep_active, 1'b0)
    `CHK(sample_rate, 3'b011)
    rd(IDX_SOURCE, {RESP_OKAY, 32'ha0});
    wr(IDX_WAKE, 8'hc2);
    wr(IDX_RATE, 8'h73);
    acc_events <= 7'h00;
    t0 = cyc;
    f0 = flush_cnt;
    for (int k = 0; k < 100 && sleep_active !== 1'b1; k++) @(negedge sys_clk);
    `CHK((cyc - t0) inside {[17:18]}, 1'b1)
    settle(3);
    `CHK(flush_cnt - f0, 0)
    `CHK(fifo_intake_en && !fifo_empty, 1'b0)
    final_report();
  end
endmodule
